// [common/opp_pkg.sv]
/*
 * Shared constants and types for the one-time PROM programming controller.
 * Assumes a single 50 MHz clock and a device held active by the controller's own reset output,
 * with its supply-select output raised only for writes, never for reads.
 */
package opp_pkg;

    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 8;
    localparam int PAGE_BYTES = 4;
    localparam int PAGE_W     = DATA_W * PAGE_BYTES;
    localparam int TMR_W      = 16;

    // Clock and pin timing
    localparam int CLK_NS     = 20;
    localparam int PULSE_NS   = 100000;
    localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_NS  = 80;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC   = 2;

    localparam int MAX_TRIES  = 10;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 17'h0EFFF;

    typedef enum logic [1:0] {
        OPP_READ,
        OPP_BYTE_WR,
        OPP_PAGE_WR
    } opp_op_t;

    typedef enum logic [2:0] {
        OPP_IDLE,
        OPP_SUPPLY,
        OPP_LATCH,
        OPP_PULSE,
        OPP_RECOV,
        OPP_VERIFY,
        OPP_RDWAIT,
        OPP_DONE
    } opp_state_t;

endpackage

// [src/opp_timer.sv]
/*
 * Down counter for pin timing: loads len on start, pulses done when one is left.
 * Assumes start is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
module opp_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } opp_tmr_state_t;

    opp_tmr_state_t q_r;
    opp_tmr_state_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (start) begin
            q_nxt.cnt = len;
        end else if (q_r.cnt != '0) begin
            q_nxt.cnt = q_r.cnt - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign done = (q_r.cnt == W'(1));

endmodule

// [src/opp_programmer.sv]
/*
 * Programmer that drives a one-time PROM through its address, data and strobe pins:
 * read, byte write and four-byte page write, each write verified with retries.
 * Assumes commands from logic on clk; data_pins_i comes from the pin and is synchronised.
 */
`timescale 1ns/1ps
// Function
// - Page latch: chip select high, output gate low, strobe high, four bytes latched.
// - After latching, one 0.1 ms low strobe pulse with select and gate high.
// - After page write, verify with select and gate both low.
// - Repeat pulse then verify, at most 10 attempts in total.
// - Byte write: 0.1 ms pulse, select low, gate high; then gate low verifies.
// - Verify after every write before moving on.
// - For reading, present the address first, then select read mode.
// - Interface works only with device reset low and programming supply raised; reads here run with the supply low.
// - Write only addresses 0000H to EFFFH.
module opp_programmer #(
    parameter int PULSE_CYC  = opp_pkg::PULSE_CYC,
    parameter int SETTLE_CYC = opp_pkg::SETTLE_CYC
) (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               cmd_valid,
    output logic                                    cmd_ready,
    input  wire opp_pkg::opp_op_t                   cmd_op,
    input  wire logic [opp_pkg::ADDR_W-1:0]         cmd_addr,
    input  wire logic [opp_pkg::PAGE_W-1:0]         cmd_data,
    output logic                                    rsp_valid,
    output logic                                    rsp_ok,
    output logic [opp_pkg::DATA_W-1:0]              rsp_data,
    output logic [3:0]                              rsp_attempts,
    output logic [opp_pkg::ADDR_W-1:0]              address_pins,
    output logic [opp_pkg::DATA_W-1:0]              data_pins_o,
    input  wire logic [opp_pkg::DATA_W-1:0]         data_pins_i,
    output logic                                    data_pins_oe,
    output logic                                    chip_select_low,
    output logic                                    output_gate_low,
    output logic                                    program_strobe_low,
    output logic                                    prog_supply_high,
    output logic                                    device_reset_low
);

    localparam int VER_MAX = 64;
    localparam logic [opp_pkg::TMR_W-1:0] PULSE_LEN  = opp_pkg::TMR_W'(PULSE_CYC - 1);
    localparam logic [opp_pkg::TMR_W-1:0] SETTLE_LEN = opp_pkg::TMR_W'(SETTLE_CYC - 1);
    localparam logic [opp_pkg::TMR_W-1:0] SAMPLE_LEN =
        opp_pkg::TMR_W'(SETTLE_CYC + opp_pkg::SYNC_CYC - 1);

    typedef struct packed {
        opp_pkg::opp_state_t         st;
        opp_pkg::opp_op_t            op;
        logic [opp_pkg::ADDR_W-1:0]  base;
        logic [opp_pkg::PAGE_W-1:0]  wdata;
        logic [1:0]                  idx;
        logic [3:0]                  tries;
        logic                        ce_n;
        logic                        oe_n;
        logic                        pgm_n;
        logic                        vpp;
        logic                        doe;
        logic [opp_pkg::ADDR_W-1:0]  a;
        logic [opp_pkg::DATA_W-1:0]  dout;
        logic [opp_pkg::DATA_W-1:0]  s1;
        logic [opp_pkg::DATA_W-1:0]  s2;
        logic                        rv;
        logic                        ok;
        logic [opp_pkg::DATA_W-1:0]  rd;
        logic                        go;
        logic [opp_pkg::TMR_W-1:0]   len;
    } opp_main_state_t;

    opp_main_state_t q_r;
    opp_main_state_t q_nxt;
    logic            tmr_done;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [opp_pkg::DATA_W-1:0] opp_byte(
        input logic [opp_pkg::PAGE_W-1:0] w,
        input logic [1:0]                 i
    );
        opp_byte = w[i*opp_pkg::DATA_W +: opp_pkg::DATA_W];
    endfunction

    // Standby pins: select, gate and strobe high, data released
    function automatic opp_main_state_t opp_standby(input opp_main_state_t s);
        opp_main_state_t r;
        r       = s;
        r.ce_n  = 1'b1;
        r.oe_n  = 1'b1;
        r.pgm_n = 1'b1;
        r.doe   = 1'b0;
        return r;
    endfunction

    function automatic opp_main_state_t opp_finish(input opp_main_state_t s, input logic good);
        opp_main_state_t r;
        r     = opp_standby(s);
        r.st  = opp_pkg::OPP_DONE;
        r.vpp = 1'b0;
        r.ok  = good;
        return r;
    endfunction

    // Start one program pulse and count it as an attempt
    function automatic opp_main_state_t opp_pulse(input opp_main_state_t s);
        opp_main_state_t r;
        r       = s;
        r.st    = opp_pkg::OPP_PULSE;
        r.tries = s.tries + 4'h1;
        r.pgm_n = 1'b0;
        r.oe_n  = 1'b1;
        if (s.op == opp_pkg::OPP_PAGE_WR) begin
            r.ce_n = 1'b1;
            r.doe  = 1'b0;
        end else begin
            r.ce_n = 1'b0;
            r.doe  = 1'b1;
            r.a    = s.base;
            r.dout = opp_byte(s.wdata, 2'h0);
        end
        r.go  = 1'b1;
        r.len = PULSE_LEN;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        q_nxt    = q_r;
        q_nxt.go = 1'b0;
        q_nxt.rv = 1'b0;
        q_nxt.s1 = data_pins_i;
        q_nxt.s2 = q_r.s1;
        case (q_r.st)
            opp_pkg::OPP_IDLE: begin
                q_nxt = opp_standby(q_nxt);
                if (cmd_valid) begin
                    q_nxt.op    = cmd_op;
                    q_nxt.wdata = cmd_data;
                    q_nxt.idx   = 2'h0;
                    q_nxt.tries = 4'h0;
                    q_nxt.base  = (cmd_op == opp_pkg::OPP_PAGE_WR) ?
                                  {cmd_addr[opp_pkg::ADDR_W-1:2], 2'h0} : cmd_addr;
                    if (cmd_op != opp_pkg::OPP_READ && cmd_addr > opp_pkg::LAST_ADDR) begin
                        q_nxt = opp_finish(q_nxt, 1'b0);
                    end else if (cmd_op == opp_pkg::OPP_READ) begin
                        q_nxt.a   = cmd_addr;
                        q_nxt.st  = opp_pkg::OPP_RDWAIT;
                        q_nxt.go  = 1'b1;
                        q_nxt.len = SETTLE_LEN;
                    end else begin
                        q_nxt.vpp = 1'b1;
                        q_nxt.st  = opp_pkg::OPP_SUPPLY;
                        q_nxt.go  = 1'b1;
                        q_nxt.len = SETTLE_LEN;
                    end
                end
            end
            opp_pkg::OPP_SUPPLY: begin
                if (tmr_done && !q_r.go) begin
                    if (q_r.op == opp_pkg::OPP_PAGE_WR) begin
                        q_nxt.st    = opp_pkg::OPP_LATCH;
                        q_nxt.ce_n  = 1'b1;
                        q_nxt.oe_n  = 1'b0;
                        q_nxt.pgm_n = 1'b1;
                        q_nxt.doe   = 1'b1;
                        q_nxt.a     = q_r.base;
                        q_nxt.dout  = opp_byte(q_r.wdata, 2'h0);
                        q_nxt.go    = 1'b1;
                        q_nxt.len   = SETTLE_LEN;
                    end else begin
                        q_nxt = opp_pulse(q_nxt);
                    end
                end
            end
            opp_pkg::OPP_LATCH: begin
                if (tmr_done && !q_r.go) begin
                    if (q_r.idx == 2'h3) begin
                        q_nxt = opp_pulse(q_nxt);
                    end else begin
                        q_nxt.idx  = q_r.idx + 2'h1;
                        q_nxt.a    = {q_r.base[opp_pkg::ADDR_W-1:2], q_r.idx + 2'h1};
                        q_nxt.dout = opp_byte(q_r.wdata, q_r.idx + 2'h1);
                        q_nxt.go   = 1'b1;
                        q_nxt.len  = SETTLE_LEN;
                    end
                end
            end
            opp_pkg::OPP_PULSE: begin
                if (tmr_done && !q_r.go) begin
                    q_nxt.pgm_n = 1'b1;
                    q_nxt.st    = opp_pkg::OPP_RECOV;
                    q_nxt.go    = 1'b1;
                    q_nxt.len   = SETTLE_LEN;
                end
            end
            opp_pkg::OPP_RECOV: begin
                // Release data before the gate opens so the two drivers never fight
                q_nxt.doe = 1'b0;
                if (tmr_done && !q_r.go) begin
                    q_nxt.st   = opp_pkg::OPP_VERIFY;
                    q_nxt.ce_n = 1'b0;
                    q_nxt.oe_n = 1'b0;
                    q_nxt.idx  = 2'h0;
                    q_nxt.a    = q_r.base;
                    q_nxt.go   = 1'b1;
                    q_nxt.len  = SAMPLE_LEN;
                end
            end
            opp_pkg::OPP_VERIFY: begin
                if (tmr_done && !q_r.go) begin
                    q_nxt.rd = q_r.s2;
                    if (q_r.s2 == opp_byte(q_r.wdata, q_r.idx)) begin
                        if (q_r.op == opp_pkg::OPP_PAGE_WR && q_r.idx != 2'h3) begin
                            q_nxt.idx = q_r.idx + 2'h1;
                            q_nxt.a   = {q_r.base[opp_pkg::ADDR_W-1:2], q_r.idx + 2'h1};
                            q_nxt.go  = 1'b1;
                            q_nxt.len = SAMPLE_LEN;
                        end else begin
                            q_nxt = opp_finish(q_nxt, 1'b1);
                        end
                    end else if (q_r.tries == 4'(opp_pkg::MAX_TRIES)) begin
                        q_nxt = opp_finish(q_nxt, 1'b0);
                    end else begin
                        q_nxt = opp_pulse(q_nxt);
                    end
                end
            end
            opp_pkg::OPP_RDWAIT: begin
                // Address stood for one settle time; now enter read mode
                if (tmr_done && !q_r.go) begin
                    if (q_r.ce_n) begin
                        q_nxt.ce_n = 1'b0;
                        q_nxt.oe_n = 1'b0;
                        q_nxt.go   = 1'b1;
                        q_nxt.len  = SAMPLE_LEN;
                    end else begin
                        q_nxt.rd = q_r.s2;
                        q_nxt    = opp_finish(q_nxt, 1'b1);
                    end
                end
            end
            opp_pkg::OPP_DONE: begin
                q_nxt.rv = 1'b1;
                q_nxt.st = opp_pkg::OPP_IDLE;
            end
            default: begin
                q_nxt = opp_finish(q_nxt, 1'b0);
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_r       <= '0;
            q_r.st    <= opp_pkg::OPP_IDLE;
            q_r.ce_n  <= 1'b1;
            q_r.oe_n  <= 1'b1;
            q_r.pgm_n <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    opp_timer #(
        .W (opp_pkg::TMR_W)
    ) u_timer (
        .clk   (clk),
        .rst   (rst),
        .start (q_r.go),
        .len   (q_r.len),
        .done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cmd_ready          = (q_r.st == opp_pkg::OPP_IDLE) && !rst;
    assign rsp_valid          = q_r.rv;
    assign rsp_ok             = q_r.ok;
    assign rsp_data           = q_r.rd;
    assign rsp_attempts       = q_r.tries;
    assign address_pins       = q_r.a;
    assign data_pins_o        = q_r.dout;
    assign data_pins_oe       = q_r.doe;
    assign chip_select_low    = q_r.ce_n;
    assign output_gate_low    = q_r.oe_n;
    assign program_strobe_low = q_r.pgm_n;
    assign prog_supply_high   = q_r.vpp;
    assign device_reset_low   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [opp_pkg::TMR_W-1:0] low_cnt_r;

    always_ff @(posedge clk) begin
        if (rst || program_strobe_low) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_r + opp_pkg::TMR_W'(1);
        end
    end

    sequence s_page_pulse_end;
        $rose(program_strobe_low) && chip_select_low && (q_r.op == opp_pkg::OPP_PAGE_WR);
    endsequence

    sequence s_verify_mode;
        !chip_select_low && !output_gate_low && program_strobe_low && !data_pins_oe;
    endsequence

    a_latch_mode_pins: assert property (@(posedge clk) disable iff (rst)
        (q_r.st == opp_pkg::OPP_LATCH) |-> chip_select_low && !output_gate_low
            && program_strobe_low && data_pins_oe)
        else $error("latch mode pins wrong");

    a_pulse_width_exact: assert property (@(posedge clk) disable iff (rst)
        $rose(program_strobe_low) |-> (low_cnt_r == opp_pkg::TMR_W'(PULSE_CYC)))
        else $error("program pulse width wrong");

    a_page_verify_follows: assert property (@(posedge clk) disable iff (rst)
        s_page_pulse_end |-> ##[1:VER_MAX] s_verify_mode)
        else $error("no verify after page write");

    a_retry_limit_hit: assert property (@(posedge clk) disable iff (rst)
        (rsp_valid && !rsp_ok && q_r.op != opp_pkg::OPP_READ && rsp_attempts != 4'h0)
            |-> (rsp_attempts == 4'(opp_pkg::MAX_TRIES)))
        else $error("gave up before the attempt limit");

    a_byte_pulse_pins: assert property (@(posedge clk) disable iff (rst)
        (!program_strobe_low && q_r.op == opp_pkg::OPP_BYTE_WR)
            |-> !chip_select_low && output_gate_low && data_pins_oe)
        else $error("byte write pins wrong");

    a_byte_verify_next: assert property (@(posedge clk) disable iff (rst)
        ($rose(program_strobe_low) && q_r.op == opp_pkg::OPP_BYTE_WR)
            |-> ##[1:VER_MAX] s_verify_mode)
        else $error("no verify after byte write");

    a_read_addr_first: assert property (@(posedge clk) disable iff (rst)
        ($fell(chip_select_low) && q_r.op == opp_pkg::OPP_READ)
            |-> $stable(address_pins) && $past(q_r.st) == opp_pkg::OPP_RDWAIT)
        else $error("read mode before address");

    a_supply_during_pulse: assert property (@(posedge clk) disable iff (rst)
        !program_strobe_low |-> prog_supply_high && !device_reset_low)
        else $error("pulse without programming supply");

    a_write_addr_range: assert property (@(posedge clk) disable iff (rst)
        !program_strobe_low |-> (address_pins <= opp_pkg::LAST_ADDR))
        else $error("write outside allowed range");

endmodule

// [testbench/opp_prom_model.sv]
/*
 * Behavioural one-time PROM with the pin-level programming port.
 * Assumes the bench resolves the shared data bus and feeds it back as data_in.
 */
`timescale 1ns/1ps
module opp_prom_model #(
    parameter int MIN_PULSE_NS = 95000,
    parameter int ACC_NS       = 10
) (
    input  wire logic [opp_pkg::ADDR_W-1:0] address_pins,
    input  wire logic [opp_pkg::DATA_W-1:0] data_in,
    output logic      [opp_pkg::DATA_W-1:0] data_out,
    output logic                            data_oe,
    input  wire logic                       chip_select_low,
    input  wire logic                       output_gate_low,
    input  wire logic                       program_strobe_low,
    input  wire logic                       prog_supply_high,
    input  wire logic                       device_reset_low
);
    ////////////////////////////////////////////////////////////////////////////
    logic [opp_pkg::DATA_W-1:0] mem [0:(1<<opp_pkg::ADDR_W)-1];
    logic [opp_pkg::DATA_W-1:0] page_q [4];
    int                         fail_left;
    realtime                    fall_t;
    logic                       active;
    logic                       rd_mode;
    logic                       latch_en;
    logic [opp_pkg::DATA_W-1:0] data_d;

    // Bench sets fail_left to make pulses leave the cell unprogrammed
    initial begin
        fail_left = 0;
        fall_t = 0.0;
        for (int i = 0; i < (1 << opp_pkg::ADDR_W); i++) begin
            mem[i] = 8'hFF;
        end
    end

    assign active  = !device_reset_low;
    assign rd_mode = active && !chip_select_low && !output_gate_low
                     && program_strobe_low;
    // Any other pin state floats the outputs
    assign #(ACC_NS) data_oe  = rd_mode;
    assign #(ACC_NS) data_out = mem[address_pins];

    ////////////////////////////////////////////////////////////////////////////
    // Strobes and data change in one time step; the delayed enable drops zero-width
    // glitches and the delayed data keeps the byte past the end of latch mode
    assign #1 latch_en = active && prog_supply_high && chip_select_low && !output_gate_low
                         && program_strobe_low;
    assign #(ACC_NS) data_d = data_in;

    always @* begin
        if (latch_en) begin
            page_q[address_pins[1:0]] = data_d;
        end
    end

    always @(negedge program_strobe_low) begin
        fall_t = $realtime;
    end

    // Short pulses or a strobe held high leave the array untouched
    always @(posedge program_strobe_low) begin
        if (active && prog_supply_high && output_gate_low
            && ($realtime - fall_t) >= MIN_PULSE_NS) begin
            if (fail_left > 0) begin
                fail_left--;
            end else if (chip_select_low) begin
                for (int i = 0; i < 4; i++) begin
                    mem[{address_pins[16:2], 2'(i)}] = page_q[i];
                end
            end else begin
                mem[address_pins] = data_in;
            end
        end
    end
endmodule

// [testbench/otp_prom_program_port_bench.sv]
/*
 * Self-checking bench for the PROM programming controller against the PROM model.
 * Assumes opp_pkg is compiled first; pulse length is cut to 8 cycles.
 */
`timescale 1ns/1ps
module otp_prom_program_port_bench;
    localparam int PCYC  = 8;
    localparam int LIMIT = 6000;

    logic                            clk, rst, cmd_valid, cmd_ready;
    opp_pkg::opp_op_t                cmd_op;
    logic [opp_pkg::ADDR_W-1:0]      cmd_addr, address_pins, addr_prev;
    logic [opp_pkg::PAGE_W-1:0]      cmd_data;
    logic                            rsp_valid, rsp_ok, data_pins_oe, dev_oe, cs_prev;
    logic [opp_pkg::DATA_W-1:0]      rsp_data, data_pins_o, dev_out, data_bus, last_bus;
    logic [3:0]                      rsp_attempts;
    logic                            chip_select_low, output_gate_low, program_strobe_low;
    logic                            prog_supply_high, device_reset_low;
    int                              error_cnt, samples_checked, cyc, low_run, pulse_cnt;

    // A floating bus shows the inverse of its last driven value
    assign data_bus = data_pins_oe ? data_pins_o : (dev_oe ? dev_out : ~last_bus);

    opp_programmer #(.PULSE_CYC(PCYC), .SETTLE_CYC(4)) i_opp_programmer (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data),
        .rsp_attempts(rsp_attempts), .address_pins(address_pins),
        .data_pins_o(data_pins_o), .data_pins_i(data_bus), .data_pins_oe(data_pins_oe),
        .chip_select_low(chip_select_low), .output_gate_low(output_gate_low),
        .program_strobe_low(program_strobe_low), .prog_supply_high(prog_supply_high),
        .device_reset_low(device_reset_low));

    opp_prom_model #(.MIN_PULSE_NS(PCYC * 20), .ACC_NS(10)) i_opp_prom_model (
        .address_pins(address_pins), .data_in(data_bus), .data_out(dev_out),
        .data_oe(dev_oe), .chip_select_low(chip_select_low),
        .output_gate_low(output_gate_low), .program_strobe_low(program_strobe_low),
        .prog_supply_high(prog_supply_high), .device_reset_low(device_reset_low));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Pin monitor: pulse shape, bus ownership and read address setup
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            end_sim();
        end
        if (data_pins_oe) begin
            last_bus <= data_pins_o;
        end else if (dev_oe) begin
            last_bus <= dev_out;
        end
        if (!rst) begin
            if (data_pins_oe && dev_oe) check("bus_contention", 1, 0);
            if (!program_strobe_low) begin
                low_run++;
                check("gate_in_pulse", output_gate_low, 1);
                check("supply_in_pulse", prog_supply_high, 1);
                check("drive_in_pulse", data_pins_oe, !chip_select_low);
            end else if (low_run != 0) begin
                check("pulse_width", low_run, PCYC);
                pulse_cnt++;
                low_run = 0;
            end
            if (cs_prev && !chip_select_low && !prog_supply_high) begin
                check("read_addr_setup", address_pins, addr_prev);
            end
            cs_prev = chip_select_low;
            addr_prev = address_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic run_cmd(input opp_pkg::opp_op_t op, input logic [16:0] a,
                           input logic [31:0] d);
        int n;
        n = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge clk) #1;
            n++;
        end
        pulse_cnt = 0;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(posedge clk) #1;
            n++;
        end
        check("rsp_valid", rsp_valid, 1);
    endtask

    task automatic t_read(input logic [16:0] a, input logic [7:0] exp);
        run_cmd(opp_pkg::OPP_READ, a, 32'h0);
        check("read_data", rsp_data, exp);
        check("read_ok", rsp_ok, 1);
        check("read_attempts", rsp_attempts, 0);
    endtask

    task automatic t_write(input opp_pkg::opp_op_t op, input logic [16:0] a,
                           input logic [31:0] d, input int fails,
                           input logic ok, input logic [3:0] att);
        i_opp_prom_model.fail_left = fails;
        run_cmd(op, a, d);
        check("write_ok", rsp_ok, ok);
        check("write_attempts", rsp_attempts, att);
        check("pulse_count", pulse_cnt, att);
        i_opp_prom_model.fail_left = 0;
    endtask

    task automatic t_reset;
        check("ready_in_reset", cmd_ready, 0);
        check("strobes_idle", {chip_select_low, output_gate_low, program_strobe_low},
              3'b111);
        check("device_reset_low", device_reset_low, 0);
        check("oe_idle", data_pins_oe, 0);
    endtask

    task automatic t_byte_write;
        t_write(opp_pkg::OPP_BYTE_WR, 17'h00123, 32'h000000A5, 0, 1'b1, 4'h1);
        check("cell_byte", i_opp_prom_model.mem[17'h00123], 8'hA5);
        t_read(17'h00123, 8'hA5);
    endtask

    task automatic t_byte_retry;
        t_write(opp_pkg::OPP_BYTE_WR, 17'h00124, 32'h0000003C, 2, 1'b1, 4'h3);
        t_read(17'h00124, 8'h3C);
    endtask

    task automatic t_page_write;
        t_write(opp_pkg::OPP_PAGE_WR, 17'h00201, 32'h44332211, 0, 1'b1, 4'h1);
        check("page_last_verify", rsp_data, 8'h44);
        for (int i = 0; i < 4; i++) begin
            t_read(17'h00200 + 17'(i), 8'(8'h11 * (i + 1)));
        end
    endtask

    task automatic t_page_fail;
        t_write(opp_pkg::OPP_PAGE_WR, 17'h00300, 32'h00000000, 20, 1'b0,
                4'(opp_pkg::MAX_TRIES));
        check("cell_unwritten", i_opp_prom_model.mem[17'h00300], 8'hFF);
    endtask

    task automatic t_range;
        t_write(opp_pkg::OPP_BYTE_WR, 17'h0F000, 32'h0000005A, 0, 1'b0, 4'h0);
        t_write(opp_pkg::OPP_BYTE_WR, opp_pkg::LAST_ADDR, 32'h0000005A, 0, 1'b1,
                4'h1);
        t_read(17'h0F000, 8'hFF);
        t_read(opp_pkg::LAST_ADDR, 8'h5A);
        t_read(17'h1FFFF, 8'hFF);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = opp_pkg::OPP_READ;
        cmd_addr = '0;
        cmd_data = '0;
        last_bus = 8'h00;
        addr_prev = '0;
        cs_prev = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        low_run = 0;
        pulse_cnt = 0;
        repeat (16) @(posedge clk);
        #1;
        t_reset();
        rst = 1'b0;
        t_byte_write();
        t_byte_retry();
        t_page_write();
        t_page_fail();
        t_range();
        end_sim();
    end
endmodule
